// ---- idl_pkg.sv ----
// Purpose: constants and types for the indexed load decoder
// Assumes: byte stream of opcodes from the core fetch unit
// Notes: cycle counts are pipeline stages, one per clock when fed without stalls
package idl_pkg;
   typedef enum logic [1:0] {IDL_IDLE, IDL_OPC, IDL_DISP, IDL_RUN} idl_state_t;
   // prefix bytes
   localparam logic [7:0] PFX_INDEX = 8'hce;
   localparam logic [7:0] PFX_PAIR = 8'hcf;
   // opcode field patterns
   localparam logic [2:0] OPC_LOAD_TOP = 3'h2;
   localparam logic [5:0] OPC_PP_TOP = 6'h18;
   localparam logic [2:0] OPC_MEM_TOP = 3'h3;
   localparam logic [1:0] OPC_SEL_MID = 2'h2;
   localparam logic [3:0] OPC_PAIR_TOP = 4'he;
   // field positions
   localparam int SEL_BIT = 4;
   localparam int REG_HI = 4;
   localparam int REG_LO = 3;
   localparam int SRC_SEC_BIT = 0;
   localparam int USE_OFS_BIT = 1;
   localparam int PDST_HI = 3;
   localparam int PDST_LO = 2;
   localparam int PSRC_HI = 1;
   localparam int PSRC_LO = 0;
   // cycle counts and stage marks
   localparam logic [2:0] PAIR_CYC = 3'h2;
   localparam logic [2:0] LOAD_CYC = 3'h4;
   localparam logic [2:0] COPY_CYC = 3'h5;
   localparam logic [2:0] STG_FIRST = 3'h1;
   localparam logic [2:0] STG_OFS = 3'h2;
   localparam logic [2:0] STG_READ = 3'h3;
   localparam logic [2:0] STG_WRITE = 3'h4;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [2:0] RST_CNT = 3'h0;
   localparam logic [1:0] RST_SEL = 2'h0;
endpackage : idl_pkg

// ---- idl_decoder.sv ----
// Purpose: decode and execute indexed byte loads and register-pair copies
// Assumes: mem_rdata is valid in the same cycle as mem_req
// Notes: register file and flags live outside; this block only issues writes
module idl_decoder (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic byte_valid,
   input wire logic [7:0] byte_in,
   output logic byte_ready,
   input wire logic banked_mode,
   input wire logic [15:0] acc_pair,
   input wire logic [15:0] pair_pointer,
   input wire logic [15:0] first_index_ptr,
   input wire logic [15:0] second_index_ptr,
   input wire logic [7:0] index_offset_reg,
   input wire logic [7:0] first_index_page,
   input wire logic [7:0] second_index_page,
   input wire logic [7:0] general_page,
   input wire logic [7:0] mem_rdata,
   output logic mem_req,
   output logic mem_we,
   output logic [15:0] mem_addr,
   output logic [7:0] mem_page,
   output logic [7:0] mem_wdata,
   output logic reg_we,
   output logic [1:0] reg_sel,
   output logic [7:0] reg_wdata,
   output logic pair_we,
   output logic [1:0] pair_sel,
   output logic [15:0] pair_wdata,
   output logic flag_we,
   output logic done,
   output logic unsupported
);

   function automatic logic [15:0] idx_add(input logic [15:0] base, input logic [7:0] ofs);
      idx_add = base + {{8{ofs[7]}}, ofs};
   endfunction : idx_add

   idl_pkg::idl_state_t state_ff;
   idl_pkg::idl_state_t nxt_state;
   logic [2:0] cnt_ff;
   logic [2:0] nxt_cnt;
   logic grp_index_ff;
   logic load_ff;
   logic [15:0] src_base_ff;
   logic [7:0] src_page_ff;
   logic [15:0] dst_addr_ff;
   logic [7:0] dst_page_ff;
   logic byte_ready_ff;
   logic mem_req_ff;
   logic mem_we_ff;
   logic [15:0] mem_addr_ff;
   logic [7:0] mem_page_ff;
   logic [7:0] mem_wdata_ff;
   logic reg_we_ff;
   logic [1:0] reg_sel_ff;
   logic [7:0] reg_wdata_ff;
   logic pair_we_ff;
   logic [1:0] pair_sel_ff;
   logic [15:0] pair_wdata_ff;
   logic flag_we_ff;
   logic done_ff;
   logic unsup_ff;

   wire take = byte_ready_ff && byte_valid;
   wire take_pfx = take && state_ff == idl_pkg::IDL_IDLE;
   wire take_opc = take && state_ff == idl_pkg::IDL_OPC;
   wire take_disp = take && state_ff == idl_pkg::IDL_DISP;
   wire pfx_index = byte_in == idl_pkg::PFX_INDEX;
   wire pfx_ok = pfx_index || byte_in == idl_pkg::PFX_PAIR;

   // opcode classes, valid only while the opcode byte is offered
   wire op_load = grp_index_ff && byte_in[7:5] == idl_pkg::OPC_LOAD_TOP
      && !byte_in[2] && byte_in[1:0] != 2'h0;
   wire op_pp = grp_index_ff && byte_in[7:2] == idl_pkg::OPC_PP_TOP
      && byte_in[1:0] != 2'h0;
   wire op_sel = grp_index_ff && byte_in[7:5] == idl_pkg::OPC_MEM_TOP
      && byte_in[3:2] == idl_pkg::OPC_SEL_MID;
   wire op_pair = !grp_index_ff && byte_in[7:4] == idl_pkg::OPC_PAIR_TOP;
   wire opc_ok = op_load || op_pp || op_sel || op_pair;
   wire src_second = byte_in[idl_pkg::SRC_SEC_BIT];
   wire use_ofs = byte_in[idl_pkg::USE_OFS_BIT];
   wire sel_second = byte_in[idl_pkg::SEL_BIT];

   // operand selection, sampled when the opcode is taken
   wire [15:0] nxt_src_base = src_second ? second_index_ptr : first_index_ptr;
   wire [7:0] src_idx_page = src_second ? second_index_page : first_index_page;
   wire [7:0] nxt_src_page = banked_mode ? src_idx_page : idl_pkg::RST_BYTE;
   wire [15:0] sel_ptr = sel_second ? second_index_ptr : first_index_ptr;
   wire [15:0] nxt_dst_addr = op_pp ? pair_pointer : sel_ptr;
   wire [7:0] sel_page = sel_second ? second_index_page : first_index_page;
   wire [7:0] dst_bank_page = op_pp ? general_page : sel_page;
   wire [7:0] nxt_dst_page = banked_mode ? dst_bank_page : idl_pkg::RST_BYTE;
   wire [1:0] psrc = byte_in[idl_pkg::PSRC_HI:idl_pkg::PSRC_LO];
   wire [15:0] pair_lo_val = psrc[0] ? pair_pointer : acc_pair;
   wire [15:0] pair_hi_val = psrc[0] ? second_index_ptr : first_index_ptr;
   wire [15:0] pair_src_val = psrc[1] ? pair_hi_val : pair_lo_val;

   // pipeline stage events
   wire in_run = state_ff == idl_pkg::IDL_RUN;
   wire run_ofs = in_run && cnt_ff == idl_pkg::STG_OFS;
   wire issue_rd = take_disp || run_ofs;
   wire rd_done = in_run && cnt_ff == idl_pkg::STG_READ;
   wire wr_done = in_run && cnt_ff == idl_pkg::STG_WRITE;
   wire finish = (take_opc && op_pair) || (rd_done && load_ff) || wr_done;
   wire bad = (take_pfx && !pfx_ok) || (take_opc && !opc_ok);
   // offset byte is either the displacement on the bus or the offset register
   wire [7:0] rd_ofs = take_disp ? byte_in : index_offset_reg;
   wire [15:0] rd_addr = idx_add(src_base_ff, rd_ofs);
   wire nxt_ready = nxt_state != idl_pkg::IDL_RUN;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         idl_pkg::IDL_IDLE: begin
            if (take_pfx && pfx_ok) begin
               nxt_state = idl_pkg::IDL_OPC;
            end
         end
         idl_pkg::IDL_OPC: begin
            if (take_opc) begin
               if (!opc_ok || op_pair) begin
                  nxt_state = idl_pkg::IDL_IDLE;
               end else if (use_ofs) begin
                  nxt_state = idl_pkg::IDL_RUN;
               end else begin
                  nxt_state = idl_pkg::IDL_DISP;
               end
            end
         end
         idl_pkg::IDL_DISP: begin
            if (take_disp) begin
               nxt_state = idl_pkg::IDL_RUN;
            end
         end
         idl_pkg::IDL_RUN: begin
            if (finish) begin
               nxt_state = idl_pkg::IDL_IDLE;
            end
         end
      endcase
   end

   // stage counter: set to STG_FIRST by the taken prefix, one step per later taken byte, then one per clock in the run phase
   assign nxt_cnt = take_pfx ? idl_pkg::STG_FIRST : 3'(cnt_ff + 3'h1);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= idl_pkg::IDL_IDLE;
         cnt_ff <= idl_pkg::RST_CNT;
         byte_ready_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         byte_ready_ff <= nxt_ready;
         if (take || in_run) begin
            cnt_ff <= nxt_cnt;
         end
      end
   end

   // operands are frozen at opcode time so a later pointer update cannot tear them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         grp_index_ff <= 1'b0;
         load_ff <= 1'b0;
         src_base_ff <= idl_pkg::RST_WORD;
         src_page_ff <= idl_pkg::RST_BYTE;
         dst_addr_ff <= idl_pkg::RST_WORD;
         dst_page_ff <= idl_pkg::RST_BYTE;
         reg_sel_ff <= idl_pkg::RST_SEL;
      end else if (take_pfx) begin
         grp_index_ff <= pfx_index;
      end else if (take_opc) begin
         load_ff <= op_load;
         src_base_ff <= nxt_src_base;
         src_page_ff <= nxt_src_page;
         dst_addr_ff <= nxt_dst_addr;
         dst_page_ff <= nxt_dst_page;
         reg_sel_ff <= byte_in[idl_pkg::REG_HI:idl_pkg::REG_LO];
      end
   end

   // memory side: read in the stage after the offset is known, write one stage later
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_req_ff <= 1'b0;
         mem_we_ff <= 1'b0;
         mem_addr_ff <= idl_pkg::RST_WORD;
         mem_page_ff <= idl_pkg::RST_BYTE;
         mem_wdata_ff <= idl_pkg::RST_BYTE;
      end else begin
         mem_req_ff <= issue_rd;
         mem_we_ff <= rd_done && !load_ff;
         if (issue_rd) begin
            mem_addr_ff <= rd_addr;
            mem_page_ff <= src_page_ff;
         end else if (rd_done && !load_ff) begin
            mem_addr_ff <= dst_addr_ff;
            mem_page_ff <= dst_page_ff;
            mem_wdata_ff <= mem_rdata;
         end
      end
   end

   // register file side and completion
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_we_ff <= 1'b0;
         reg_wdata_ff <= idl_pkg::RST_BYTE;
         pair_we_ff <= 1'b0;
         pair_sel_ff <= idl_pkg::RST_SEL;
         pair_wdata_ff <= idl_pkg::RST_WORD;
         flag_we_ff <= 1'b0;
         done_ff <= 1'b0;
         unsup_ff <= 1'b0;
      end else begin
         reg_we_ff <= rd_done && load_ff;
         pair_we_ff <= take_opc && op_pair;
         flag_we_ff <= 1'b0;
         done_ff <= finish;
         unsup_ff <= bad;
         if (rd_done) begin
            reg_wdata_ff <= mem_rdata;
         end
         if (take_opc && op_pair) begin
            pair_sel_ff <= byte_in[idl_pkg::PDST_HI:idl_pkg::PDST_LO];
            pair_wdata_ff <= pair_src_val;
         end
      end
   end

   assign byte_ready = byte_ready_ff;
   assign mem_req = mem_req_ff;
   assign mem_we = mem_we_ff;
   assign mem_addr = mem_addr_ff;
   assign mem_page = mem_page_ff;
   assign mem_wdata = mem_wdata_ff;
   assign reg_we = reg_we_ff;
   assign reg_sel = reg_sel_ff;
   assign reg_wdata = reg_wdata_ff;
   assign pair_we = pair_we_ff;
   assign pair_sel = pair_sel_ff;
   assign pair_wdata = pair_wdata_ff;
   assign flag_we = flag_we_ff;
   assign done = done_ff;
   assign unsupported = unsup_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_pair_copy: assert property (take_opc && op_pair |=> pair_we_ff && done_ff
      && pair_sel_ff == $past(byte_in[3:2]) && cnt_ff == idl_pkg::PAIR_CYC)
      else $error("pair copy not written in two cycles");
   chk_disp_sext: assert property (take_disp |=> mem_req_ff
      && mem_addr_ff == $past(src_base_ff) + {{8{$past(byte_in[7])}}, $past(byte_in)})
      else $error("displacement address wrong");
   chk_ofs_sext: assert property (run_ofs |=> mem_req_ff
      && mem_addr_ff == $past(src_base_ff) + {{8{$past(index_offset_reg[7])}}, $past(index_offset_reg)})
      else $error("offset register address wrong");
   chk_load_cycles: assert property (reg_we_ff |-> done_ff && cnt_ff == idl_pkg::LOAD_CYC
      && $past(mem_req_ff) && reg_wdata_ff == $past(mem_rdata))
      else $error("register load timing or data wrong");
   chk_copy_cycles: assert property (mem_we_ff |=> done_ff && !mem_we_ff
      && cnt_ff == idl_pkg::COPY_CYC)
      else $error("memory copy not done in five cycles");
   chk_copy_data: assert property (mem_we_ff |-> $past(mem_req_ff)
      && mem_wdata_ff == $past(mem_rdata) && !mem_req_ff)
      else $error("copied byte differs from read byte");
   chk_pp_page: assert property (take_opc && op_pp |=> dst_addr_ff == $past(pair_pointer)
      && dst_page_ff == ($past(banked_mode) ? $past(general_page) : 8'h00))
      else $error("pair pointer destination page wrong");
   chk_sel_first: assert property (take_opc && op_sel && !sel_second |=>
      dst_addr_ff == $past(first_index_ptr)
      && dst_page_ff == ($past(banked_mode) ? $past(first_index_page) : 8'h00))
      else $error("first pointer destination wrong");
   chk_sel_page: assert property (take_opc && op_sel && sel_second |=>
      dst_addr_ff == $past(second_index_ptr)
      && dst_page_ff == ($past(banked_mode) ? $past(second_index_page) : 8'h00))
      else $error("selected pointer destination wrong");
   chk_src_second: assert property (take_opc && op_load && src_second |=>
      src_base_ff == $past(second_index_ptr)
      && src_page_ff == ($past(banked_mode) ? $past(second_index_page) : 8'h00))
      else $error("second pointer source wrong");
   chk_flags_kept: assert property (done_ff |-> !flag_we_ff)
      else $error("status flags written");
   chk_load_seq: assert property (take_opc && op_load && use_ofs |-> ##2 mem_req_ff ##1 reg_we_ff)
      else $error("offset register load sequence wrong");

   cov_load: cover property (reg_we_ff && reg_sel_ff == 2'h3);
   cov_copy: cover property (mem_we_ff && mem_page_ff != 8'h00);
   cov_pair: cover property (pair_we_ff && pair_sel_ff == 2'h2);
   cov_bad: cover property (unsup_ff);

endmodule : idl_decoder

// ---- idl_mem_model.sv ----
// Purpose: data memory model on the far side of the indexed load decoder
// Assumes: read data must be valid in the same cycle as the read strobe, no wait states
// Notes: content is a fixed pattern of address and page, so the bench predicts it on its own
module idl_mem_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic mem_req,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0] mem_page,
   output logic [7:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] last_ff;
   logic [7:0] pat_word;
   assign pat_word = mem_addr[7:0] ^ mem_addr[15:8] ^ mem_page ^ 8'h5a;
   // released bus shows the inverted last value, so a late sample never reads stale data
   assign mem_rdata = mem_req ? pat_word : ~last_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) last_ff <= 8'h00;
      else if (mem_req) last_ff <= pat_word;
   end
endmodule : idl_mem_model

// ---- tb.sv ----
// Purpose: self-checking bench for the indexed load decoder
// Assumes: inputs change at the falling edge, outputs sampled at the next falling edge
// Notes: cycle counts are measured from the edge that takes the prefix byte
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, byte_valid = 0, banked_mode = 1;
   logic [7:0] byte_in = 8'h00, index_offset_reg = 8'h00;
   logic [15:0] acc_pair = 16'h1234, pair_pointer = 16'h2345;
   logic [15:0] first_index_ptr = 16'h4000, second_index_ptr = 16'h8001;
   logic [7:0] first_index_page = 8'h11, second_index_page = 8'h22, general_page = 8'h33;
   logic [7:0] mem_rdata, mem_page, mem_wdata, reg_wdata;
   logic [15:0] mem_addr, pair_wdata, rd_a, wr_a, pr_d;
   logic [7:0] rd_p, wr_p, wr_d, rg_d;
   logic [1:0] reg_sel, pair_sel, rg_s, pr_s;
   logic byte_ready, mem_req, mem_we, reg_we, pair_we, flag_we, done, unsupported, dn, uns;
   logic flag_hit = 0;
   int n_errors = 0, cmp_count = 0, n_cyc, n_rd, n_wr, n_busy;
   idl_decoder idl_decoder_inst (.clk, .rst_n, .byte_valid, .byte_in, .byte_ready, .banked_mode,
      .acc_pair, .pair_pointer, .first_index_ptr, .second_index_ptr, .index_offset_reg,
      .first_index_page, .second_index_page, .general_page, .mem_rdata, .mem_req, .mem_we,
      .mem_addr, .mem_page, .mem_wdata, .reg_we, .reg_sel, .reg_wdata, .pair_we, .pair_sel,
      .pair_wdata, .flag_we, .done, .unsupported);
   idl_mem_model idl_mem_model_inst (.clk, .rst_n, .mem_req, .mem_addr, .mem_page, .mem_rdata);
   always #5 clk = ~clk;
   function automatic logic [7:0] pat(input logic [15:0] a, input logic [7:0] p);
      return a[7:0] ^ a[15:8] ^ p ^ 8'h5a;
   endfunction : pat
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic give_verdict();
      $display("comparisons %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : give_verdict
   // one instruction: bytes offered without stalls, strobes captured until done or refusal
   task automatic exec(input logic [7:0] pfx, input logic [7:0] op, input logic [7:0] d, input int nb);
      n_cyc = 0;
      {dn, uns} = 2'b00;
      {n_rd, n_wr, n_busy} = 96'h0;
      {rd_a, rd_p, wr_a, wr_p, wr_d, rg_s, rg_d, pr_s, pr_d} = 'x;
      for (int n = 0; n < 12; n++) begin
         @(negedge clk);
         if (byte_ready !== 1'b1) n_busy++;
         if (mem_req === 1'b1) begin
            {rd_a, rd_p} = {mem_addr, mem_page};
            n_rd++;
         end
         if (mem_we === 1'b1) begin
            {wr_a, wr_p, wr_d} = {mem_addr, mem_page, mem_wdata};
            n_wr++;
         end
         if (reg_we === 1'b1) {rg_s, rg_d} = {reg_sel, reg_wdata};
         if (pair_we === 1'b1) {pr_s, pr_d} = {pair_sel, pair_wdata};
         if (flag_we !== 1'b0) flag_hit = 1'b1;
         if (n > 0 && (done === 1'b1 || unsupported === 1'b1)) begin
            n_cyc = n;
            {dn, uns} = {done, unsupported};
         end
         byte_valid = (n < nb) && (n_cyc == 0);
         byte_in = (n == 0) ? pfx : ((n == 1) ? op : d);
         if (n_cyc != 0) break;
      end
   endtask : exec
   task automatic t_disp_loads();
      logic [7:0] d;
      logic [15:0] ea;
      for (int k = 0; k < 8; k++) begin
         d = k[0] ? 8'h80 : 8'h7f;
         ea = second_index_ptr + {{8{d[7]}}, d};
         exec(8'hce, {3'b010, k[2:1], 3'b001}, d, 3);
         chk("disp load cycles", n_cyc, 4);
         chk("disp load addr", {rd_a, rd_p}, {ea, second_index_page});
         chk("disp load reg", {rg_s, rg_d}, {k[2:1], pat(ea, second_index_page)});
         chk("disp load strobes", {n_rd[3:0], n_wr[3:0], n_busy[3:0]}, 12'h101);
      end
   endtask : t_disp_loads
   task automatic t_ofs_loads();
      logic [15:0] ea;
      logic [7:0] pg;
      for (int k = 0; k < 8; k++) begin
         index_offset_reg = k[1] ? 8'hff : 8'h7f;
         ea = (k[0] ? second_index_ptr : first_index_ptr) + {{8{index_offset_reg[7]}}, index_offset_reg};
         pg = k[0] ? second_index_page : first_index_page;
         exec(8'hce, {3'b010, k[2:1], 2'b01, k[0]}, 8'h00, 2);
         chk("ofs load cycles", n_cyc, 4);
         chk("ofs load addr", {rd_a, rd_p}, {ea, pg});
         chk("ofs load reg", {rg_s, rg_d}, {k[2:1], pat(ea, pg)});
         chk("ofs load strobes", {n_rd[3:0], n_wr[3:0], n_busy[3:0]}, 12'h102);
      end
   endtask : t_ofs_loads
   // second pass runs unbanked, where every page must read as zero
   task automatic t_copies();
      logic [7:0] cp[11] = '{8'h61, 8'h68, 8'h78, 8'h69, 8'h79, 8'h62, 8'h6a, 8'h7a, 8'h63, 8'h6b, 8'h7b};
      logic [7:0] op, d, sp, dp;
      logic [15:0] sa, da;
      d = 8'hfe;
      index_offset_reg = 8'h80;
      for (int i = 0; i < 22; i++) begin
         banked_mode = (i < 11);
         op = cp[i % 11];
         sa = (op[0] ? second_index_ptr : first_index_ptr)
            + (op[1] ? {{8{index_offset_reg[7]}}, index_offset_reg} : {{8{d[7]}}, d});
         sp = banked_mode ? (op[0] ? second_index_page : first_index_page) : 8'h00;
         da = !op[3] ? pair_pointer : (op[4] ? second_index_ptr : first_index_ptr);
         dp = !op[3] ? general_page : (op[4] ? second_index_page : first_index_page);
         if (!banked_mode) dp = 8'h00;
         exec(8'hce, op, d, op[1] ? 2 : 3);
         chk("copy cycles", n_cyc, 5);
         chk("copy source", {rd_a, rd_p}, {sa, sp});
         chk("copy dest", {wr_a, wr_p, wr_d}, {da, dp, pat(sa, sp)});
         chk("copy strobes", {n_rd[3:0], n_wr[3:0], n_busy[3:0]}, {8'h11, op[1] ? 4'h3 : 4'h2});
      end
   endtask : t_copies
   task automatic t_pairs();
      logic [15:0] pv[4];
      pv = '{acc_pair, pair_pointer, first_index_ptr, second_index_ptr};
      for (int k = 0; k < 16; k++) begin
         exec(8'hcf, {4'he, k[3:0]}, 8'h00, 2);
         chk("pair cycles", n_cyc, 2);
         chk("pair write", {pr_s, pr_d}, {k[3:2], pv[k[1:0]]});
         chk("pair strobes", {n_rd[3:0], n_wr[3:0], n_busy[3:0]}, 12'h000);
      end
   endtask : t_pairs
   task automatic t_refuse();
      exec(8'h55, 8'h00, 8'h00, 1);
      chk("bad prefix", {n_cyc[3:0], dn, uns}, {4'h1, 2'b01});
      exec(8'hce, 8'h40, 8'h00, 2);
      chk("bad opcode", {n_cyc[3:0], dn, uns}, {4'h2, 2'b01});
      exec(8'hcf, 8'hf0, 8'h00, 2);
      chk("bad pair opcode", {n_cyc[3:0], dn, uns}, {4'h2, 2'b01});
      chk("flag write seen", flag_hit, 1'b0);
   endtask : t_refuse
   // reset while a copy has its read out: strobes drop at once and the next load runs clean
   task automatic t_reset();
      logic [15:0] ea;
      ea = second_index_ptr + 16'h0010;
      @(negedge clk);
      {banked_mode, byte_valid, byte_in} = {2'b11, 8'hce};
      @(negedge clk);
      byte_in = 8'h61;
      @(negedge clk);
      byte_in = 8'h10;
      @(negedge clk);
      chk("read before reset", mem_req, 1'b1);
      {byte_valid, rst_n} = 2'b00;
      #1;
      chk("reset outputs", {byte_ready, mem_req, mem_we, reg_we, pair_we, done, unsupported}, 7'h40);
      @(negedge clk);
      rst_n = 1'b1;
      exec(8'hce, 8'h41, 8'h10, 3);
      chk("load after reset", {n_cyc[3:0], rg_s, rg_d}, {4'h4, 2'h0, pat(ea, second_index_page)});
   endtask : t_reset
   initial begin
      repeat (12) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      t_disp_loads();
      t_ofs_loads();
      t_copies();
      t_pairs();
      t_refuse();
      t_reset();
      give_verdict();
   end
   // the whole sequence needs well under a thousand cycles
   initial begin
      #100us;
      n_errors++;
      give_verdict();
   end
endmodule : tb
